// *** pkg/rkd_pkg.sv ***
/*
 * shared constants and types for the remote key input decoder.
 * assumes a 25 MHz system clock and a 32-bit apb register bus.
 */
package rkd_pkg;

    // ************************************************
    // timing
    // ************************************************
    localparam int unsigned CLK_HZ    = 25_000_000;
    localparam int unsigned T_MIN_MS  = 20;    // least qualified high time
    localparam int unsigned T_ESC_MS  = 1000;  // escape pulse is shorter
    localparam int unsigned T_LONG_MS = 2000;  // confirm hold is longer
    localparam int unsigned T_REP_MS  = 250;   // local key auto-repeat period
    localparam int unsigned MIN_CYC   = (CLK_HZ / 1000) * T_MIN_MS;
    localparam int unsigned ESC_CYC   = (CLK_HZ / 1000) * T_ESC_MS;
    localparam int unsigned LONG_CYC  = (CLK_HZ / 1000) * T_LONG_MS;
    localparam int unsigned REP_CYC   = (CLK_HZ / 1000) * T_REP_MS;
    localparam int          CW        = 26;    // duration counter width

    // ************************************************
    // key inputs and parameters
    // ************************************************
    localparam int NIN   = 7;                  // qualified input count
    localparam int I_DEC = 0;                  // remote decrement
    localparam int I_ENT = 1;                  // remote enter/escape
    localparam int I_INC = 2;                  // remote increment
    localparam int L_DEC = 3;                  // local decrement key
    localparam int L_ENT = 4;                  // local enter key
    localparam int L_INC = 5;                  // local increment key
    localparam int I_RMT = 6;                  // remote select
    localparam int K_DEC = 0;
    localparam int K_ENT = 1;
    localparam int K_INC = 2;
    localparam int PW    = 4;
    localparam int POSW  = 16;
    localparam logic [PW-1:0] PAR_MIN  = 4'h0;
    localparam logic [PW-1:0] PAR_MAX  = 4'hf;
    localparam logic [PW-1:0] AMP_RST  = 4'h2;
    localparam logic [PW-1:0] CUSH_RST = 4'h4;
    localparam logic [PW-1:0] SYS_RST  = 4'h1;

    // ************************************************
    // register map
    // ************************************************
    localparam int          AW         = 8;
    localparam logic [7:0]  ADDR_CTRL  = 8'h00;
    localparam logic [7:0]  ADDR_STAT  = 8'h04;
    localparam logic [7:0]  ADDR_PAR   = 8'h08;
    localparam logic [7:0]  ADDR_MID   = 8'h0c;
    localparam int          CTRL_MOD   = 0;    // start modify mode
    localparam int          ST_LSB     = 0;    // state field
    localparam int          ST_RMT     = 4;
    localparam int          ST_RDY     = 5;
    localparam int          ST_ENT     = 6;
    localparam int          PAR_A_LSB  = 0;
    localparam int          PAR_C_LSB  = 8;
    localparam int          PAR_S_LSB  = 16;

    typedef enum logic [2:0] {
        ST_OPERATE = 3'b000,
        ST_PAR_AMP = 3'b001,
        ST_PAR_CUS = 3'b010,
        ST_PAR_SYS = 3'b011,
        ST_ARMED   = 3'b100,
        ST_TEACH   = 3'b101,
        ST_MID     = 3'b110
    } rkd_state_e;

    typedef struct packed {
        logic          psel;
        logic          penable;
        logic          pwrite;
        logic [AW-1:0] paddr;
        logic [31:0]   pwdata;
    } rkd_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rkd_apb_rsp_s;

    typedef struct packed {
        logic [PW-1:0] amp;
        logic [PW-1:0] cush;
        logic [PW-1:0] sys;
    } rkd_par_s;

    typedef struct packed {
        rkd_state_e      st;
        logic [2:0]      kprev;
        logic            allprev;
        logic            ent_arm;
        logic [CW-1:0]   ent_cnt;
        logic [CW-1:0]   rep_cnt;
        rkd_par_s        par;
        logic [POSW-1:0] mid;
        logic            ready;
        logic            tstart;
        logic            tabort;
        logic            erase;
        logic            jdn;
        logic            jup;
        logic            mstore;
        rkd_apb_rsp_s    rsp;
    } rkd_top_st_s;

endpackage : rkd_pkg

// *** design/rkd_input_qual.sv ***
/*
 * synchronises input pins and qualifies each high level by a least time.
 * assumes pins are asynchronous to clk; reset is already synchronised.
 */
`timescale 1ns/1ps
module rkd_input_qual
    import rkd_pkg::*;
#(
    parameter int          N       = NIN,
    parameter int unsigned MIN_CYC = rkd_pkg::MIN_CYC
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] pin,
    output logic      [N-1:0] level,
    output logic      [N-1:0] held
);
    localparam logic [CW-1:0] MIN_C = CW'(MIN_CYC - 1);

    typedef struct packed {
        logic [N-1:0]         s1;
        logic [N-1:0]         s2;
        logic [N-1:0]         held;
        logic [N-1:0][CW-1:0] cnt;
    } rkd_qual_st_s;

    rkd_qual_st_s s_reg, s_next;

    // ************************************************
    // two-flop sync, then count the high time
    // ************************************************
    always_comb begin
        s_next    = s_reg;
        s_next.s1 = pin;
        s_next.s2 = s_reg.s1;
        for (int i = 0; i < N; i++) begin
            if (!s_reg.s2[i]) begin
                s_next.cnt[i]  = '0;  // short pulses never qualify
                s_next.held[i] = 1'b0;
            end else if (s_reg.cnt[i] == MIN_C) begin
                s_next.held[i] = 1'b1;
            end else begin
                s_next.cnt[i] = s_reg.cnt[i] + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign level = s_reg.s2;
    assign held  = s_reg.held;
endmodule : rkd_input_qual

// *** design/rkd_top.sv ***
/*
 * remote key input decoder: turns remote or local key inputs into the
 * parameter, teach and jog commands of a positioning controller.
 * assumes teach_done, at_first_end and position_in come from logic on
 * sys_clk; key pins and remote select are asynchronous.
 */
// Overview of operation
// RULE1: remote select high: local keys ignored
// RULE2: remote dec, enter, inc from inputs five-seven
// RULE3: position mode: held decrement jogs toward zero
// RULE4: parameter mode: each decrement pulse lowers one step
// RULE5: position mode: held increment jogs away from zero
// RULE6: parameter mode: each increment pulse raises one step
// RULE7: enter held over two seconds confirms
// RULE8: enter pulse under one second escapes
// RULE9: no acknowledge returned to external controller
// RULE10: remote inputs never auto-repeat parameter steps
// RULE11: amplification, then cushioning, then system parameter
// RULE12: confirming system parameter arms teach procedure
// RULE13: mid teach: drive moves only while held
// RULE14: mid teach: long enter stores position
// RULE15: teach complete at first end: ready high
// RULE16: parameter change erases end positions, clears ready
// RULE17: inputs synchronised, pulses under 20 ms ignored; remote select is used as the synchronised level, not filtered
`timescale 1ns/1ps
module rkd_top
    import rkd_pkg::*;
#(
    parameter int unsigned MIN_CYCLES  = rkd_pkg::MIN_CYC,
    parameter int unsigned ESC_CYCLES  = rkd_pkg::ESC_CYC,
    parameter int unsigned LONG_CYCLES = rkd_pkg::LONG_CYC,
    parameter int unsigned REP_CYCLES  = rkd_pkg::REP_CYC
) (
    input  wire logic            sys_clk,
    input  wire logic            nrst,
    input  wire rkd_apb_req_s    apb_req,
    output rkd_apb_rsp_s         apb_rsp,
    input  wire logic            remote_select_input,
    input  wire logic            decrement_input,
    input  wire logic            enter_escape_input,
    input  wire logic            increment_input,
    input  wire logic            local_dec_key,
    input  wire logic            local_enter_key,
    input  wire logic            local_inc_key,
    input  wire logic [POSW-1:0] position_in,
    input  wire logic            teach_done,
    input  wire logic            at_first_end,
    output logic                 ready_output,
    output logic                 teach_start,
    output logic                 teach_abort,
    output logic                 erase_teach,
    output logic                 drive_jog_down,
    output logic                 drive_jog_up,
    output logic                 mid_store,
    output logic      [POSW-1:0] mid_position,
    output rkd_par_s             par_out,
    output rkd_state_e           disp_state
);
    localparam logic [CW-1:0] LONG_C = CW'(LONG_CYCLES);
    localparam logic [CW-1:0] ESC_C  = CW'(ESC_CYCLES);
    localparam logic [CW-1:0] REP_C  = CW'(REP_CYCLES - 1);

    // ************************************************
    // reset release
    // ************************************************
    logic rst_meta;
    logic rst_n;

    // async assert, two-flop release
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ************************************************
    // input qualification
    // ************************************************
    logic [NIN-1:0] pins;
    logic [NIN-1:0] lvl;
    logic [NIN-1:0] hld;

    assign pins = {remote_select_input, local_inc_key, local_enter_key,
                   local_dec_key, increment_input, enter_escape_input,
                   decrement_input};

    rkd_input_qual #(
        .N       (NIN),
        .MIN_CYC (MIN_CYCLES)
    ) u_qual (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .pin   (pins),
        .level (lvl),
        .held  (hld)
    );

    // ************************************************
    // helpers
    // ************************************************
    // one step up or down, saturating
    function automatic logic [PW-1:0] step(input logic [PW-1:0] v,
                                           input logic up,
                                           input logic dn);
        logic [PW-1:0] r;
        r = v;
        if (up && !dn && v != PAR_MAX) begin
            r = v + 1'b1;
        end else if (dn && !up && v != PAR_MIN) begin
            r = v - 1'b1;
        end
        return r;
    endfunction : step

    function automatic logic mapped(input logic [AW-1:0] a);
        return a == ADDR_CTRL || a == ADDR_STAT || a == ADDR_PAR ||
               a == ADDR_MID;
    endfunction : mapped

    rkd_top_st_s s_reg, s_next;
    logic        remote;
    logic [2:0]  k;
    logic [2:0]  rise;
    logic        long_ev;
    logic        esc_ev;
    logic        rep_ev;
    logic        up_ev;
    logic        dn_ev;
    logic        all3;
    logic        wr_ok;
    logic        wr_ctrl;
    logic        wr_par;
    logic        enter_mod;
    rkd_par_s    par_tmp;
    logic [31:0] rdata;

    // ************************************************
    // decoder, sequence and register logic
    // ************************************************
    always_comb begin
        s_next        = s_reg;
        s_next.tstart = 1'b0;
        s_next.tabort = 1'b0;
        s_next.erase  = 1'b0;
        s_next.mstore = 1'b0;
        rep_ev        = 1'b0;
        rdata         = '0;
        par_tmp       = s_reg.par;

        // key source select
        remote = lvl[I_RMT];
        if (remote) begin
            k = {hld[I_INC], hld[I_ENT], hld[I_DEC]};  // RULE1 RULE2
        end else begin
            k = {hld[L_INC], hld[L_ENT], hld[L_DEC]};
        end
        rise         = k & ~s_reg.kprev;
        s_next.kprev = k;

        // enter hold time: long confirm or short escape
        if (!k[K_ENT]) begin
            s_next.ent_cnt = '0;
            s_next.ent_arm = 1'b1;
        end else if (s_reg.ent_cnt != LONG_C) begin
            s_next.ent_cnt = s_reg.ent_cnt + 1'b1;
        end
        long_ev = k[K_ENT] && s_reg.ent_arm &&
                  (s_reg.ent_cnt == LONG_C - 1'b1);  // RULE7
        esc_ev  = !k[K_ENT] && s_reg.kprev[K_ENT] && s_reg.ent_arm &&
                  (s_reg.ent_cnt < ESC_C);  // RULE8
        if (long_ev) begin
            s_next.ent_arm = 1'b0;  // one confirm per press
        end

        // auto-repeat, local keys only
        if (remote || !(k[K_INC] ^ k[K_DEC])) begin
            s_next.rep_cnt = '0;  // RULE10
        end else if (s_reg.rep_cnt == REP_C) begin
            s_next.rep_cnt = '0;
            rep_ev         = 1'b1;
        end else begin
            s_next.rep_cnt = s_reg.rep_cnt + 1'b1;
        end
        up_ev = rise[K_INC] || (rep_ev && k[K_INC]);  // RULE6
        dn_ev = rise[K_DEC] || (rep_ev && k[K_DEC]);  // RULE4

        // all three keys together open modify mode
        all3           = &k;
        s_next.allprev = all3;

        // apb slave, one wait state
        wr_ok   = apb_req.psel && apb_req.penable && s_reg.rsp.pready &&
                  apb_req.pwrite && mapped(apb_req.paddr);
        wr_ctrl = wr_ok && apb_req.paddr == ADDR_CTRL;
        wr_par  = wr_ok && apb_req.paddr == ADDR_PAR;
        s_next.rsp.pready = apb_req.psel && apb_req.penable &&
                            !s_reg.rsp.pready;
        unique case (apb_req.paddr)
            ADDR_STAT: begin
                rdata[ST_LSB +: 3] = s_reg.st;
                rdata[ST_RMT]      = remote;
                rdata[ST_RDY]      = s_reg.ready;
                rdata[ST_ENT]      = k[K_ENT];
            end
            ADDR_PAR: begin
                rdata[PAR_A_LSB +: PW] = s_reg.par.amp;
                rdata[PAR_C_LSB +: PW] = s_reg.par.cush;
                rdata[PAR_S_LSB +: PW] = s_reg.par.sys;
            end
            ADDR_MID: rdata[POSW-1:0] = s_reg.mid;
            default:  rdata = '0;
        endcase
        if (s_next.rsp.pready) begin
            s_next.rsp.prdata  = apb_req.pwrite ? '0 : rdata;
            s_next.rsp.pslverr = !mapped(apb_req.paddr);
        end else begin
            s_next.rsp.prdata  = '0;
            s_next.rsp.pslverr = 1'b0;
        end
        enter_mod = (all3 && !s_reg.allprev) ||
                    (wr_ctrl && apb_req.pwdata[CTRL_MOD]);

        // sequence: parameters, teach arm, teach, mid teach
        unique case (s_reg.st)
            ST_OPERATE, ST_MID: begin
                if (enter_mod) begin
                    s_next.st      = ST_PAR_AMP;
                    s_next.ent_arm = 1'b0;
                end else if (s_reg.st == ST_MID && long_ev) begin
                    s_next.mstore = 1'b1;  // RULE14
                    s_next.mid    = position_in;
                end
            end
            ST_PAR_AMP: begin
                par_tmp.amp = step(s_reg.par.amp, up_ev, dn_ev);  // RULE4 RULE6
                if (long_ev) begin
                    s_next.st = ST_PAR_CUS;  // RULE11
                end else if (esc_ev) begin
                    s_next.st = ST_OPERATE;
                end
            end
            ST_PAR_CUS: begin
                par_tmp.cush = step(s_reg.par.cush, up_ev, dn_ev);
                if (long_ev) begin
                    s_next.st = ST_PAR_SYS;  // RULE11
                end else if (esc_ev) begin
                    s_next.st = ST_OPERATE;
                end
            end
            ST_PAR_SYS: begin
                par_tmp.sys = step(s_reg.par.sys, up_ev, dn_ev);
                if (long_ev) begin
                    s_next.st = ST_ARMED;  // RULE12
                end else if (esc_ev) begin
                    s_next.st = ST_OPERATE;
                end
            end
            ST_ARMED: begin
                if (long_ev) begin
                    s_next.st     = ST_TEACH;  // RULE7
                    s_next.tstart = 1'b1;
                end else if (esc_ev) begin
                    s_next.st = ST_OPERATE;  // RULE8
                end
            end
            ST_TEACH: begin
                if (esc_ev) begin
                    s_next.st     = ST_OPERATE;  // RULE8
                    s_next.tabort = 1'b1;
                end else if (teach_done && at_first_end) begin
                    s_next.st    = ST_MID;
                    s_next.ready = 1'b1;  // RULE15
                end
            end
            default: s_next.st = ST_OPERATE;
        endcase

        // software may load parameters directly
        if (wr_par) begin
            par_tmp.amp  = apb_req.pwdata[PAR_A_LSB +: PW];
            par_tmp.cush = apb_req.pwdata[PAR_C_LSB +: PW];
            par_tmp.sys  = apb_req.pwdata[PAR_S_LSB +: PW];
        end
        s_next.par = par_tmp;
        if (par_tmp != s_reg.par) begin
            s_next.erase = 1'b1;  // RULE16
            s_next.ready = 1'b0;
        end

        // jog only in position mode while one key is held
        s_next.jdn = (s_reg.st == ST_MID) && k[K_DEC] && !k[K_INC];  // RULE3 RULE13
        s_next.jup = (s_reg.st == ST_MID) && k[K_INC] && !k[K_DEC];  // RULE5 RULE13
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg          <= '0;
            s_reg.st       <= ST_OPERATE;
            s_reg.par.amp  <= AMP_RST;
            s_reg.par.cush <= CUSH_RST;
            s_reg.par.sys  <= SYS_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ************************************************
    // outputs, display only, no acknowledge lines
    // ************************************************
    assign apb_rsp        = s_reg.rsp;
    assign ready_output   = s_reg.ready;
    assign teach_start    = s_reg.tstart;
    assign teach_abort    = s_reg.tabort;
    assign erase_teach    = s_reg.erase;
    assign drive_jog_down = s_reg.jdn;
    assign drive_jog_up   = s_reg.jup;
    assign mid_store      = s_reg.mstore;
    assign mid_position   = s_reg.mid;
    assign par_out        = s_reg.par;  // RULE9
    assign disp_state     = s_reg.st;

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_local_ignored;
        remote && !hld[I_INC] && !hld[I_DEC] && !wr_par |=> $stable(s_reg.par);
    endproperty
    a_local_ignored: assert property (p_local_ignored) else $error("local key stepped"); // RULE1

    property p_remote_map;
        remote |-> k == {hld[I_INC], hld[I_ENT], hld[I_DEC]};
    endproperty
    a_remote_map: assert property (p_remote_map) else $error("remote key map wrong"); // RULE2

    property p_jog_down;
        s_reg.st == ST_MID && k[K_DEC] && !k[K_INC] |=> drive_jog_down && !drive_jog_up;
    endproperty
    a_jog_down: assert property (p_jog_down) else $error("no jog down"); // RULE3

    property p_dec_step;
        s_reg.st == ST_PAR_AMP && rise[K_DEC] && !rise[K_INC] && s_reg.par.amp != PAR_MIN
            && !wr_par |=> s_reg.par.amp == $past(s_reg.par.amp) - 1'b1;
    endproperty
    a_dec_step: assert property (p_dec_step) else $error("decrement step wrong"); // RULE4

    property p_jog_up;
        s_reg.st == ST_MID && k[K_INC] && !k[K_DEC] |=> drive_jog_up && !drive_jog_down;
    endproperty
    a_jog_up: assert property (p_jog_up) else $error("no jog up"); // RULE5

    property p_inc_step;
        s_reg.st == ST_PAR_CUS && rise[K_INC] && !rise[K_DEC] && s_reg.par.cush != PAR_MAX
            && !wr_par |=> s_reg.par.cush == $past(s_reg.par.cush) + 1'b1;
    endproperty
    a_inc_step: assert property (p_inc_step) else $error("increment step wrong"); // RULE6

    property p_long;
        long_ev |-> k[K_ENT] && s_reg.ent_cnt == LONG_C - 1'b1;
    endproperty
    a_long: assert property (p_long) else $error("long enter timing"); // RULE7

    property p_esc;
        s_reg.st == ST_TEACH && esc_ev |=> s_reg.st == ST_OPERATE && teach_abort;
    endproperty
    a_esc: assert property (p_esc) else $error("escape did not abort"); // RULE8

    property p_no_repeat;
        remote && s_reg.st == ST_PAR_AMP && k[K_INC] && !rise[K_INC] && !rise[K_DEC]
            && !wr_par |=> $stable(s_reg.par.amp);
    endproperty
    a_no_repeat: assert property (p_no_repeat) else $error("remote auto-repeat"); // RULE10

    property p_order;
        s_reg.st == ST_PAR_AMP && long_ev |=> s_reg.st == ST_PAR_CUS;
    endproperty
    a_order: assert property (p_order) else $error("parameter order wrong"); // RULE11

    property p_arm;
        s_reg.st == ST_PAR_SYS && long_ev |=> s_reg.st == ST_ARMED;
    endproperty
    a_arm: assert property (p_arm) else $error("teach not armed"); // RULE12

    property p_jog_stop;
        !k[K_INC] && !k[K_DEC] |=> !drive_jog_up && !drive_jog_down;
    endproperty
    a_jog_stop: assert property (p_jog_stop) else $error("jog not stopped"); // RULE13

    property p_mid;
        s_reg.st == ST_MID && long_ev && !enter_mod
            |=> mid_store && mid_position == $past(position_in);
    endproperty
    a_mid: assert property (p_mid) else $error("mid not stored"); // RULE14

    property p_ready;
        s_reg.st == ST_TEACH && teach_done && at_first_end && !esc_ev
            && par_tmp == s_reg.par |=> ready_output;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not set"); // RULE15

    property p_erase;
        !$stable(s_reg.par) |-> erase_teach && !ready_output;
    endproperty
    a_erase: assert property (p_erase) else $error("no erase on change"); // RULE16

    property p_qual;
        $rose(hld[I_DEC]) |-> $past(lvl[I_DEC]) && $past(lvl[I_DEC], 2);
    endproperty
    a_qual: assert property (p_qual) else $error("unqualified key"); // RULE17

    c_teach: cover property (s_reg.st == ST_ARMED && long_ev);
    c_mid:   cover property (mid_store);
    c_esc:   cover property (esc_ev && s_reg.st != ST_OPERATE);
    c_step:  cover property (remote && up_ev && s_reg.st == ST_PAR_AMP);
endmodule : rkd_top

// *** testbench/rkd_key_src.sv ***
/* remote key source: drives the three remote inputs like a plc.
   assumes sys_clk from the bench; inputs rest low between presses. */
`timescale 1ns/1ps
module rkd_key_src (
    input  wire logic sys_clk,
    output logic      dec_o,
    output logic      ent_o,
    output logic      inc_o
);
    initial {inc_o, ent_o, dec_o} = 3'h0;
    // hold key mask for n cycles, then a settle gap
    task automatic press(input logic [2:0] m, input int n);
        @(posedge sys_clk);
        {inc_o, ent_o, dec_o} <= m;
        repeat (n) @(posedge sys_clk);
        {inc_o, ent_o, dec_o} <= 3'h0;
        repeat (16) @(posedge sys_clk);
    endtask : press
endmodule : rkd_key_src

// *** testbench/remote_key_input_decoder_tb.sv ***
/* bench: remote keys, teach flow, apb; short counts 8/40/80/20.
   assumes the key source model drives the remote inputs. */
`timescale 1ns/1ps
module remote_key_input_decoder_tb;
    import rkd_pkg::*;
    logic sys_clk = 1'b0, nrst = 1'b0, rmt = 1'b0, td = 1'b0;
    rkd_apb_req_s req = '0;
    rkd_apb_rsp_s rsp;
    wire logic    dec, ent, inc;
    logic         ju, jd, rdy, er;
    logic [2:0]   lk = 3'h0;
    logic [3:0]   pl;  // teach start, abort, erase, mid store
    logic [15:0]  midp, pos = 16'h0;
    int unsigned  hits [4] = '{0, 0, 0, 0};
    logic [31:0]  rd;
    rkd_par_s     par;
    rkd_state_e   st;
    int           error_cnt = 0, tests_run = 0;
    always #20 sys_clk = ~sys_clk;
    rkd_key_src src (.sys_clk(sys_clk), .dec_o(dec), .ent_o(ent), .inc_o(inc));
    rkd_top #(.MIN_CYCLES(8), .ESC_CYCLES(40), .LONG_CYCLES(80), .REP_CYCLES(20)) uut (
        .sys_clk(sys_clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp),
        .remote_select_input(rmt), .decrement_input(dec), .enter_escape_input(ent),
        .increment_input(inc), .local_dec_key(lk[0]), .local_enter_key(lk[1]),
        .local_inc_key(lk[2]), .position_in(pos), .teach_done(td), .at_first_end(td),
        .ready_output(rdy), .teach_start(pl[0]), .teach_abort(pl[1]), .erase_teach(pl[2]),
        .drive_jog_down(jd), .drive_jog_up(ju), .mid_store(pl[3]), .mid_position(midp),
        .par_out(par), .disp_state(st));
    // count one-cycle pulses of the design
    always @(posedge sys_clk) begin
        if (nrst) begin
            foreach (hits[i]) hits[i] <= hits[i] + pl[i];
        end
    end
    // compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // one apb transfer, waits for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask : apb
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    // parameter stepping, glitch and local key rejection
    task automatic t_param;
        src.press(3'h7, 20);
        chk(st, ST_PAR_AMP);
        src.press(3'h4, 60);
        chk(par.amp, 4'h3);
        src.press(3'h1, 20);
        chk(par.amp, 4'h2);
        src.press(3'h1, 3);
        chk(par.amp, 4'h2);
        lk <= 3'h7;
        repeat (40) @(posedge sys_clk);
        lk <= 3'h0;
        chk(par.amp, 4'h2);
        chk(hits[2], 2);
    endtask : t_param
    // confirm chain, teach start and ready
    task automatic t_teach;
        src.press(3'h2, 100);
        chk(st, ST_PAR_CUS);
        src.press(3'h2, 100);
        chk(st, ST_PAR_SYS);
        src.press(3'h2, 100);
        chk(st, ST_ARMED);
        src.press(3'h2, 100);
        chk(st, ST_TEACH);
        td <= 1'b1;
        repeat (4) @(posedge sys_clk);
        td <= 1'b0;
        chk(rdy, 1'b1);
        chk(hits[0], 1);
    endtask : t_teach
    // jog while held, store mid-position
    task automatic t_mid;
        pos <= 16'h0a5c;
        fork
            src.press(3'h4, 40);
            begin
                repeat (30) @(posedge sys_clk);
                chk({ju, jd}, 2'b10);
            end
        join
        chk({ju, jd}, 2'b00);
        fork
            src.press(3'h1, 40);
            begin
                repeat (30) @(posedge sys_clk);
                chk({ju, jd}, 2'b01);
            end
        join
        chk({ju, jd}, 2'b00);
        src.press(3'h2, 100);
        chk(midp, 16'h0a5c);
        chk(hits[3], 1);
    endtask : t_mid
    // parameter change erases, escape, unmapped address
    task automatic t_esc;
        pos <= 16'h1234;
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_PAR, 32'h00010405);
        repeat (2) @(posedge sys_clk);
        chk(rdy, 1'b0);
        chk(hits[2], 3);
        chk(par, 12'h541);
        apb(1'b0, ADDR_PAR, 32'h0);
        chk(rd, 32'h00010405);
        apb(1'b0, ADDR_MID, 32'h0);
        chk(rd, 32'h0a5c);
        chk(midp, 16'h0a5c);
        src.press(3'h2, 20);
        chk(st, ST_OPERATE);
        apb(1'b0, 8'h10, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h1);
        repeat (4) src.press(3'h2, 100);
        chk(st, ST_TEACH);
        src.press(3'h2, 20);
        chk(st, ST_OPERATE);
        chk(hits[1], 1);
    endtask : t_esc
    initial begin
        #(40 * 20000);
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        rmt <= 1'b1;
        repeat (6) @(posedge sys_clk);
        t_param();
        t_teach();
        t_mid();
        t_esc();
        final_report();
    end
endmodule : remote_key_input_decoder_tb
